// [include/rct_pkg.sv]
// Overview of operation
// - Stop-on-receive halts first timer after four bits
// - Trimming modes ignore first stop-on-receive bit
// - Start-mode field selects start condition
// - Auto-reload set: reload and continue at zero, except trimming without underflow, which stops
// - Auto-reload clear: stop at zero until start
// - Every underflow sets the timer interrupt flag
// - Clock select 00 fast tick, 01 slow
// - First timer cascades third/second timer underflows
// - Start copies 16-bit reload word into counter
// - Reload writes affect only next start or auto-reload
// - Live counter readable as two bytes
// - Second timer offers same stop-on-receive bit
// - Second stop-on-receive ignored while trimming
// - Second timer cascades first/third timer underflows
// - Global control low nibble masks running bits
package rct_pkg;
  localparam int          NUM_TIMERS    = 2;
  localparam int          ADDR_W        = 8;
  localparam int          ADDR_LSB      = 2;
  // Register indices; byte address is four times the index
  localparam logic [5:0]  IDX_GLOBAL    = 6'h0e;
  localparam logic [5:0]  IDX_T0_CTRL   = 6'h0f;
  localparam logic [5:0]  IDX_T0_RLD_HI = 6'h10;
  localparam logic [5:0]  IDX_T0_RLD_LO = 6'h11;
  localparam logic [5:0]  IDX_T0_CNT_HI = 6'h12;
  localparam logic [5:0]  IDX_T0_CNT_LO = 6'h13;
  localparam logic [5:0]  IDX_T1_CTRL   = 6'h14;
  localparam logic [5:0]  IDX_T1_RLD_HI = 6'h15;
  localparam logic [5:0]  IDX_T1_RLD_LO = 6'h16;
  localparam logic [5:0]  IDX_T1_CNT_HI = 6'h17;
  localparam logic [5:0]  IDX_T1_CNT_LO = 6'h18;
  localparam logic [5:0]  IDX_IRQ_STAT  = 6'h20;
  localparam logic [5:0]  IDX_IRQ_EN    = 6'h21;
  localparam logic [5:0]  IDX_IRQ_CLR   = 6'h22;
  // Control register fields
  localparam int          STOP_RX_BIT   = 7;
  localparam int          MODE_HI       = 5;
  localparam int          MODE_LO       = 4;
  localparam int          AUTO_BIT      = 3;
  localparam int          CLK_HI        = 1;
  localparam int          CLK_LO        = 0;
  localparam logic [7:0]  CTRL_WR_MASK  = 8'hbb;
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [15:0] RELOAD_RST    = 16'h0000;
  localparam logic [15:0] COUNT_RST     = 16'h0000;
  localparam logic [15:0] COUNT_ONE     = 16'h0001;
  localparam int          RUN_POS       = 4;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  typedef enum logic [1:0] {
    START_NONE = 2'h0,
    START_TX   = 2'h1,
    TRIM_NOUF  = 2'h2,
    TRIM_UF    = 2'h3
  } rct_start_t;
  typedef enum logic [1:0] {
    CLK_FAST   = 2'h0,
    CLK_SLOW   = 2'h1,
    CLK_CASC_A = 2'h2,
    CLK_CASC_B = 2'h3
  } rct_clk_t;
endpackage : rct_pkg

// [rtl/rct_timer.sv]
`timescale 1ns/1ps
module rct_timer (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic                        ce,
  input  wire logic                        tick_fast,
  input  wire logic                        tick_slow,
  input  wire logic                        tx_end,
  input  wire logic                        rx_four_bits,
  input  wire logic                        lfo_in,
  input  wire logic                        timer2_underflow,
  input  wire logic [rct_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [rct_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  output logic                             irq,
  output logic [rct_pkg::NUM_TIMERS-1:0]   underflow
);
  localparam int N = rct_pkg::NUM_TIMERS;

  logic                   aw_got_ff;
  logic                   w_got_ff;
  logic [5:0]             wr_idx_ff;
  logic [7:0]             wdata_ff;
  logic                   wstrb0_ff;
  logic                   bvalid_ff;
  logic [1:0]             bresp_ff;
  logic                   rvalid_ff;
  logic [31:0]            rdata_ff;
  logic [1:0]             rresp_ff;
  logic                   do_write;
  logic                   wr_en;
  logic                   wr_ok;
  logic [5:0]             rd_idx;
  logic [7:0]             rd_byte;
  logic                   rd_ok;
  logic [7:0]             ctrl_ff    [N];
  logic [15:0]            reload_ff  [N];
  logic [15:0]            count_ff   [N];
  logic [N-1:0]           running_ff;
  logic [N-1:0]           uf_ff;
  logic [N-1:0]           status_ff;
  logic [N-1:0]           nxt_status;
  logic [N-1:0]           enable_ff;
  logic [N-1:0]           clr_mask;
  logic [N-1:0]           casc_a;
  logic [N-1:0]           casc_b;
  logic [N-1:0]           gw_hit;
  logic                   lfo_q_ff;
  logic                   lfo_rise;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  function automatic logic idx_mapped(input logic [5:0] idx);
    unique case (idx)
      rct_pkg::IDX_GLOBAL,    rct_pkg::IDX_T0_CTRL,   rct_pkg::IDX_T0_RLD_HI,
      rct_pkg::IDX_T0_RLD_LO, rct_pkg::IDX_T0_CNT_HI, rct_pkg::IDX_T0_CNT_LO,
      rct_pkg::IDX_T1_CTRL,   rct_pkg::IDX_T1_RLD_HI, rct_pkg::IDX_T1_RLD_LO,
      rct_pkg::IDX_T1_CNT_HI, rct_pkg::IDX_T1_CNT_LO, rct_pkg::IDX_IRQ_STAT,
      rct_pkg::IDX_IRQ_EN,    rct_pkg::IDX_IRQ_CLR:   idx_mapped = 1'b1;
      default:                                        idx_mapped = 1'b0;
    endcase
  endfunction : idx_mapped

  // Write channel: address and data may arrive in either order
  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready  = !w_got_ff && !bvalid_ff;
  assign do_write      = aw_got_ff && w_got_ff;
  assign wr_ok         = idx_mapped(wr_idx_ff);
  // Registers are one byte wide, so only lane 0 carries a write
  assign wr_en         = do_write && wr_ok && wstrb0_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      wr_idx_ff <= 6'h00;
      wdata_ff  <= 8'h00;
      wstrb0_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= rct_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        wr_idx_ff <= s_axi_awaddr[rct_pkg::ADDR_W-1:rct_pkg::ADDR_LSB];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff  <= 1'b1;
        wdata_ff  <= s_axi_wdata[7:0];
        wstrb0_ff <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_ok ? rct_pkg::RESP_OKAY : rct_pkg::RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Software-written configuration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int k = 0; k < N; k++) begin
        ctrl_ff[k]   <= rct_pkg::CTRL_RST;
        reload_ff[k] <= rct_pkg::RELOAD_RST;
      end
      enable_ff <= '0;
    end else if (ce && wr_en) begin
      unique case (wr_idx_ff)
        rct_pkg::IDX_T0_CTRL:   ctrl_ff[0] <= wdata_ff & rct_pkg::CTRL_WR_MASK;
        rct_pkg::IDX_T1_CTRL:   ctrl_ff[1] <= wdata_ff & rct_pkg::CTRL_WR_MASK;
        rct_pkg::IDX_T0_RLD_HI: reload_ff[0][15:8] <= wdata_ff;
        rct_pkg::IDX_T0_RLD_LO: reload_ff[0][7:0]  <= wdata_ff;
        rct_pkg::IDX_T1_RLD_HI: reload_ff[1][15:8] <= wdata_ff;
        rct_pkg::IDX_T1_RLD_LO: reload_ff[1][7:0]  <= wdata_ff;
        rct_pkg::IDX_IRQ_EN:    enable_ff <= wdata_ff[N-1:0];
        default:                ;
      endcase
    end
  end

  // Read channel
  assign rd_idx        = s_axi_araddr[rct_pkg::ADDR_W-1:rct_pkg::ADDR_LSB];
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  always_comb begin
    rd_ok   = idx_mapped(rd_idx);
    rd_byte = 8'h00;
    unique case (rd_idx)
      rct_pkg::IDX_GLOBAL:    rd_byte = {{(4-N){1'b0}}, running_ff, 4'h0};
      rct_pkg::IDX_T0_CTRL:   rd_byte = ctrl_ff[0];
      rct_pkg::IDX_T0_RLD_HI: rd_byte = reload_ff[0][15:8];
      rct_pkg::IDX_T0_RLD_LO: rd_byte = reload_ff[0][7:0];
      rct_pkg::IDX_T0_CNT_HI: rd_byte = count_ff[0][15:8];
      rct_pkg::IDX_T0_CNT_LO: rd_byte = count_ff[0][7:0];
      rct_pkg::IDX_T1_CTRL:   rd_byte = ctrl_ff[1];
      rct_pkg::IDX_T1_RLD_HI: rd_byte = reload_ff[1][15:8];
      rct_pkg::IDX_T1_RLD_LO: rd_byte = reload_ff[1][7:0];
      rct_pkg::IDX_T1_CNT_HI: rd_byte = count_ff[1][15:8];
      rct_pkg::IDX_T1_CNT_LO: rd_byte = count_ff[1][7:0];
      rct_pkg::IDX_IRQ_STAT:  rd_byte = {{(8-N){1'b0}}, status_ff};
      rct_pkg::IDX_IRQ_EN:    rd_byte = {{(8-N){1'b0}}, enable_ff};
      default:                rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= rct_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= {24'h00_0000, rd_byte};
        rresp_ff  <= rd_ok ? rct_pkg::RESP_OKAY : rct_pkg::RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // Trimming edges come from a synchronous level, so one register finds the rise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lfo_q_ff <= 1'b0;
    end else if (ce) begin
      lfo_q_ff <= lfo_in;
    end
  end
  assign lfo_rise = lfo_in && !lfo_q_ff;

  // Cascade sources use last cycle's underflow to keep the ring free of loops
  assign casc_a = {uf_ff[0], timer2_underflow};
  assign casc_b = {timer2_underflow, uf_ff[1]};
  assign underflow = uf_ff;

  generate
    for (genvar i = 0; i < N; i++) begin : g_tmr
      rct_pkg::rct_start_t mode;
      rct_pkg::rct_clk_t   csel;
      logic                trim;
      logic                tick;
      logic                start_evt;
      logic                stop_evt;
      logic                rx_stop;
      logic                gw_val;
      logic                free;

      assign mode   = rct_pkg::rct_start_t'(ctrl_ff[i][rct_pkg::MODE_HI:rct_pkg::MODE_LO]);
      assign csel   = rct_pkg::rct_clk_t'(ctrl_ff[i][rct_pkg::CLK_HI:rct_pkg::CLK_LO]);
      assign trim   = (mode == rct_pkg::TRIM_NOUF) || (mode == rct_pkg::TRIM_UF);
      assign gw_hit[i] = wr_en && (wr_idx_ff == rct_pkg::IDX_GLOBAL) && wdata_ff[i];
      assign gw_val = wdata_ff[rct_pkg::RUN_POS+i];
      assign rx_stop = ctrl_ff[i][rct_pkg::STOP_RX_BIT] && !trim && rx_four_bits;
      // Trimming starts on a rising edge while idle and stops on the next one
      assign start_evt = ((mode == rct_pkg::START_TX) && tx_end) ||
                         (trim && lfo_rise && !running_ff[i]);
      assign stop_evt  = rx_stop || (trim && lfo_rise && running_ff[i]);
      assign free      = !gw_hit[i] && !stop_evt && !start_evt;

      always_comb begin
        unique case (csel)
          rct_pkg::CLK_FAST:   tick = tick_fast;
          rct_pkg::CLK_SLOW:   tick = tick_slow;
          rct_pkg::CLK_CASC_A: tick = casc_a[i];
          rct_pkg::CLK_CASC_B: tick = casc_b[i];
        endcase
      end

      // Explicit software control wins over events, stops win over starts
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          running_ff[i] <= 1'b0;
          count_ff[i]   <= rct_pkg::COUNT_RST;
          uf_ff[i]      <= 1'b0;
        end else if (ce) begin
          uf_ff[i] <= 1'b0;
          if (gw_hit[i]) begin
            running_ff[i] <= gw_val;
            if (gw_val) begin
              count_ff[i] <= reload_ff[i];
            end
          end else if (stop_evt) begin
            running_ff[i] <= 1'b0;
          end else if (start_evt) begin
            running_ff[i] <= 1'b1;
            count_ff[i]   <= reload_ff[i];
          end else if (tick && running_ff[i]) begin
            if (count_ff[i] <= rct_pkg::COUNT_ONE) begin
              // Trimming without underflow just parks at zero
              uf_ff[i] <= (mode != rct_pkg::TRIM_NOUF);
              if (ctrl_ff[i][rct_pkg::AUTO_BIT] && (mode != rct_pkg::TRIM_NOUF)) begin
                count_ff[i] <= reload_ff[i];
              end else begin
                count_ff[i]   <= rct_pkg::COUNT_RST;
                running_ff[i] <= 1'b0;
              end
            end else begin
              count_ff[i] <= count_ff[i] - rct_pkg::COUNT_ONE;
            end
          end
        end
      end

      property p_stop_rx;
        ce && rx_stop && running_ff[i] && !gw_hit[i] |=> !running_ff[i];
      endproperty
      a_stop_rx: assert property (p_stop_rx) else $error("Stop on receive missed");

      property p_trim_ignores_rx;
        ce && trim && rx_four_bits && running_ff[i] && !lfo_rise && !gw_hit[i] && !tick
          |=> running_ff[i];
      endproperty
      a_trim_ignores_rx: assert property (p_trim_ignores_rx) else $error("Receive stopped trimming timer");

      property p_auto_reload;
        ce && free && tick && running_ff[i] && count_ff[i] == rct_pkg::COUNT_ONE &&
          ctrl_ff[i][rct_pkg::AUTO_BIT] && mode != rct_pkg::TRIM_NOUF
          |=> running_ff[i] && count_ff[i] == $past(reload_ff[i]) && uf_ff[i];
      endproperty
      a_auto_reload: assert property (p_auto_reload) else $error("Auto reload failed");

      property p_one_shot;
        ce && free && tick && running_ff[i] && count_ff[i] == rct_pkg::COUNT_ONE &&
          !ctrl_ff[i][rct_pkg::AUTO_BIT]
          |=> !running_ff[i] && count_ff[i] == rct_pkg::COUNT_RST
              ##1 (!running_ff[i] || $past(start_evt) || $past(gw_hit[i]));
      endproperty
      a_one_shot: assert property (p_one_shot) else $error("One-shot did not stop at zero");

      property p_irq_flag;
        ce && uf_ff[i] |=> status_ff[i];
      endproperty
      a_irq_flag: assert property (p_irq_flag) else $error("Underflow flag not set");

      property p_start_load;
        ce && start_evt && !stop_evt && !gw_hit[i] |=> running_ff[i] && count_ff[i] == $past(reload_ff[i]);
      endproperty
      a_start_load: assert property (p_start_load) else $error("Start did not load reload word");

      property p_reload_quiet;
        ce && wr_en && running_ff[i] && !tick && free |=> count_ff[i] == $past(count_ff[i]);
      endproperty
      a_reload_quiet: assert property (p_reload_quiet) else $error("Counter disturbed by write");

      property p_decrement;
        ce && free && tick && running_ff[i] && count_ff[i] > rct_pkg::COUNT_ONE
          |=> count_ff[i] == $past(count_ff[i]) - rct_pkg::COUNT_ONE && !uf_ff[i];
      endproperty
      a_decrement: assert property (p_decrement) else $error("Counter step not one");

      property p_mask_off;
        ce && wr_en && wr_idx_ff == rct_pkg::IDX_GLOBAL && !wdata_ff[i] && !stop_evt && !start_evt && !tick
          |=> running_ff[i] == $past(running_ff[i]);
      endproperty
      a_mask_off: assert property (p_mask_off) else $error("Masked running bit changed");

      c_underflow: cover property (ce && uf_ff[i]);
      c_rx_stop:   cover property (ce && rx_stop && running_ff[i]);
      c_reload:    cover property (ce && tick && running_ff[i] && count_ff[i] == rct_pkg::COUNT_ONE &&
                                   ctrl_ff[i][rct_pkg::AUTO_BIT]);
    end
  endgenerate

  // Interrupt status: an underflow in the clear cycle keeps its bit
  assign clr_mask   = (wr_en && wr_idx_ff == rct_pkg::IDX_IRQ_CLR) ? wdata_ff[N-1:0] : '0;
  assign nxt_status = (status_ff & ~clr_mask) | uf_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_ff <= '0;
    end else if (ce) begin
      status_ff <= nxt_status;
    end
  end

  assign irq = |(status_ff & enable_ff);

  c_irq: cover property (irq);
endmodule : rct_timer

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic        aclk;
  logic        aresetn       = 1'b0;
  logic        ce            = 1'b1;
  // Event inputs: 0 fast tick, 1 slow tick, 2 tx end, 3 rx bits, 4 lfo, 5 third timer underflow
  logic [5:0]  stim          = 6'h00;
  logic [7:0]  s_axi_awaddr  = 8'h00;
  logic [7:0]  s_axi_araddr  = 8'h00;
  logic [31:0] s_axi_wdata   = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb   = 4'hf;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid  = 1'b0;
  // Response ready lines stay high, so no task ever lowers and raises them in one step
  logic        s_axi_bready  = 1'b1;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready  = 1'b1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, underflow;
  logic [31:0] s_axi_rdata;
  int          err_count     = 0;
  int          num_checks    = 0;
  int          uf0           = 0;
  int          uf1           = 0;

  rct_timer u_rct_timer (
    .aclk, .aresetn, .ce, .tick_fast(stim[0]), .tick_slow(stim[1]), .tx_end(stim[2]),
    .rx_four_bits(stim[3]), .lfo_in(stim[4]), .timer2_underflow(stim[5]),
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .underflow
  );

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // Counting pulses avoids pinning the exact cycle of the underflow strobe;
  // mid-cycle sampling makes the count current when a task resumes on the next edge
  always @(negedge aclk) begin
    if (underflow[0] === 1'b1) uf0 <= uf0 + 1;
    if (underflow[1] === 1'b1) uf1 <= uf1 + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er = rct_pkg::RESP_OKAY);
    logic a;
    logic w;
    a = 1'b0;
    w = 1'b0;
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_wdata   <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (!(a && w)) begin
      @(posedge aclk);
      if (!a && s_axi_awready === 1'b1) begin
        a = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, er);
  endtask : wr

  task automatic rd(input logic [5:0] idx, input logic [7:0] exp, input logic [1:0] er = rct_pkg::RESP_OKAY);
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, {24'h00_0000, exp});
    chk(s_axi_rresp, er);
  endtask : rd

  // A level held for n edges counts as n events, except on lfo (bit 4), where only the rise counts
  task automatic pulse(input int b, input int n);
    stim[b] <= 1'b1;
    repeat (n) @(posedge aclk);
    stim[b] <= 1'b0;
    @(posedge aclk);
  endtask : pulse

  task automatic t_reset();
    rd(6'h0f, 8'h00);
    rd(6'h13, 8'h00);
    rd(6'h3f, 8'h00, rct_pkg::RESP_SLVERR);
    wr(6'h3f, 8'h5a, rct_pkg::RESP_SLVERR);
    wr(6'h0f, 8'hff);
    rd(6'h0f, 8'hbb);
    wr(6'h14, 8'hff);
    rd(6'h14, 8'hbb);
    // Lane 0 strobe low: accepted but the byte register keeps its value
    s_axi_wstrb <= 4'he;
    wr(6'h0f, 8'h00);
    s_axi_wstrb <= 4'hf;
    rd(6'h0f, 8'hbb);
    wr(6'h0f, 8'h00);
    wr(6'h14, 8'h00);
  endtask : t_reset

  task automatic t_oneshot();
    wr(6'h10, 8'h01);
    wr(6'h11, 8'h03);
    wr(6'h0e, 8'h10);
    rd(6'h0e, 8'h00);
    wr(6'h0e, 8'h11);
    rd(6'h0e, 8'h10);
    rd(6'h12, 8'h01);
    rd(6'h13, 8'h03);
    pulse(0, 3);
    rd(6'h13, 8'h00);
    wr(6'h11, 8'h07);
    pulse(1, 2);
    rd(6'h12, 8'h01);
    rd(6'h13, 8'h00);
    pulse(0, 256);
    chk(uf0, 1);
    pulse(0, 2);
    rd(6'h13, 8'h00);
    rd(6'h0e, 8'h00);
    chk(uf0, 1);
    rd(6'h20, 8'h01);
    chk(irq, 1'b0);
    wr(6'h21, 8'h01);
    chk(irq, 1'b1);
    wr(6'h22, 8'h01);
    chk(irq, 1'b0);
  endtask : t_oneshot

  task automatic t_auto();
    wr(6'h10, 8'h00);
    wr(6'h11, 8'h02);
    wr(6'h0f, 8'h09);
    wr(6'h0e, 8'h11);
    pulse(0, 4);
    rd(6'h13, 8'h02);
    // Clock enable low must freeze the counter against ticks
    ce <= 1'b0;
    pulse(1, 3);
    ce <= 1'b1;
    rd(6'h13, 8'h02);
    pulse(1, 7);
    rd(6'h13, 8'h01);
    chk(uf0, 4);
    wr(6'h0e, 8'h01);
    rd(6'h0e, 8'h00);
  endtask : t_auto

  task automatic t_modes();
    wr(6'h11, 8'h05);
    pulse(2, 1);
    rd(6'h0e, 8'h00);
    wr(6'h0f, 8'h10);
    pulse(2, 1);
    rd(6'h0e, 8'h10);
    pulse(3, 1);
    rd(6'h0e, 8'h10);
    wr(6'h0f, 8'h90);
    pulse(3, 1);
    rd(6'h0e, 8'h00);
    wr(6'h0f, 8'ha0);
    pulse(4, 1);
    pulse(3, 1);
    rd(6'h0e, 8'h10);
    pulse(0, 3);
    pulse(4, 1);
    rd(6'h0e, 8'h00);
    rd(6'h13, 8'h02);
    wr(6'h0f, 8'hb0);
    pulse(4, 1);
    pulse(0, 5);
    chk(uf0, 5);
    wr(6'h0e, 8'h01);
  endtask : t_modes

  task automatic t_casc();
    wr(6'h0f, 8'h02);
    wr(6'h11, 8'h02);
    wr(6'h0e, 8'h11);
    pulse(0, 3);
    pulse(5, 1);
    rd(6'h13, 8'h01);
    wr(6'h0f, 8'h03);
    wr(6'h16, 8'h01);
    wr(6'h0e, 8'h22);
    pulse(0, 1);
    rd(6'h13, 8'h00);
    chk(uf1, 1);
    chk(uf0, 6);
    wr(6'h14, 8'h02);
    wr(6'h0f, 8'h00);
    wr(6'h0e, 8'h33);
    pulse(0, 2);
    repeat (4) @(posedge aclk);
    chk(uf1, 2);
    wr(6'h16, 8'h05);
    wr(6'h14, 8'h80);
    wr(6'h0e, 8'h22);
    pulse(3, 1);
    rd(6'h0e, 8'h00);
    wr(6'h14, 8'ha0);
    pulse(4, 1);
    pulse(3, 1);
    rd(6'h0e, 8'h20);
  endtask : t_casc

  task automatic give_verdict();
    if (err_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  // Whole sequence needs under a thousand cycles; the 20000-cycle limit leaves wide margin
  initial begin
    #800000;
    err_count++;
    give_verdict();
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_oneshot();
    t_auto();
    t_modes();
    t_casc();
    give_verdict();
  end
endmodule : testbench
